// ==== design/selftest_params.svh ====
// Constants of the starter self-test sequencer
// Assumes inclusion by the package and the sequencer module
`ifndef SELFTEST_PARAMS_SVH
`define SELFTEST_PARAMS_SVH
`define CLK_FREQ_HZ        200000000
`define EVT_ENTER          8'hc1
`define EVT_PASS           8'hc3
`define EVT_ABORT_DISC     8'hc4
`define EVT_ABORT_POWER    8'hc5
`define EVT_ABORT_CMD      8'hc6
`define FAULT_INLINE       8'h31
`define FAULT_BYPASS       8'h30
`define TOTAL_TEST_S       285
`define RELAY_PHASE_S      30
`define GATE_STEP_S        25
`define ALL_GATES_S        15
`define TOTAL_CHECK_S      (4 * `RELAY_PHASE_S + 6 * `GATE_STEP_S + `ALL_GATES_S)
`define GATE_SEQ_ORDER     18'o635241
`endif

// ==== design/selftest_pkg.sv ====
// Types of the starter self-test sequencer
// Assumes nothing beyond the constants header
`include "selftest_params.svh"
package selftest_pkg;
    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_LOG_ENTER = 4'b0001,
        ST_WAIT_OPEN = 4'b0010,
        ST_IL_CLOSE  = 4'b0011,
        ST_IL_OPEN   = 4'b0100,
        ST_BP_CLOSE  = 4'b0101,
        ST_BP_OPEN   = 4'b0110,
        ST_GATE_SEQ  = 4'b0111,
        ST_GATE_ALL  = 4'b1000,
        ST_PASS      = 4'b1001,
        ST_FAULT     = 4'b1010,
        ST_ABORT     = 4'b1011
    } state_t;

    typedef enum logic [3:0] {
        SHOW_HOME      = 4'h0,
        SHOW_OPEN_DISC = 4'h1,
        SHOW_IL_CLOSED = 4'h2,
        SHOW_IL_OPEN   = 4'h3,
        SHOW_BP_CLOSED = 4'h4,
        SHOW_BP_OPEN   = 4'h5,
        SHOW_GATE_N    = 4'h6,
        SHOW_ALL_GATES = 4'h7,
        SHOW_PASSED    = 4'h8,
        SHOW_FAULT     = 4'h9,
        SHOW_CANCEL    = 4'ha
    } show_t;
endpackage : selftest_pkg

// ==== design/starter_selftest_sequencer.sv ====
// Self-test sequencer of a medium-voltage solid state starter
// Assumes synchronous inputs, a one-cycle ENTER pulse and an external event recorder
// Operation
// - On start, log event 193, then sample the disconnect input
// - While disconnect closed, hold off and prompt to open it
// - Display shows the current activity at every step
// - ENTER advances any timed activity before its time elapses
// - Whole sequence without skips lasts nominally 285 seconds
// - In-line test cycles run relays on and off, checking feedback both ways
// - In-line feedback not following within timeout raises fault 49
// - In-line test passes when no input is the in-line feedback
// - In-line test skipped when its timeout setting is off
// - Bypass test cycles bypass and at-speed relays, checking feedback both ways
// - Bypass feedback not following within timeout raises fault 48
// - Bypass test passes when bypass relay is fan and no feedback input
// - Gates fire singly in order G6 G3 G5 G2 G4 G1, shown
// - ENTER during sequential gate test moves on to the next step
// - Final step drives all gates and shows all-gates-on until ENTER or its time elapses
// - ENTER in the all-gates step ends the procedure
// - On completion, log pass event 195 and reset the system
// - Abort on disconnect close, power, or command withdrawal, logging cause
// - Sequence begins with the in-line contactor test, or with the bypass test when the in-line timeout setting is off
`timescale 1ns/100ps
`include "selftest_params.svh"
module starter_selftest_sequencer #(
    parameter int          CLK_HZ      = `CLK_FREQ_HZ,
    parameter longint      RELAY_CYC   = longint'(`RELAY_PHASE_S) * `CLK_FREQ_HZ,
    parameter longint      GATE_CYC    = longint'(`GATE_STEP_S) * `CLK_FREQ_HZ,
    parameter longint      ALL_CYC     = longint'(`ALL_GATES_S) * `CLK_FREQ_HZ,
    parameter int          TMO_W       = 16,
    parameter longint      TMO_UNIT    = `CLK_FREQ_HZ / 10
) (
    // Clock and reset
    input  wire logic               CLOCK,
    input  wire logic               ARST_N,
    // Command and operator
    input  wire logic               SELFTEST_CMD,
    input  wire logic               ENTER_KEY,
    // Plant state
    input  wire logic               DISCONNECT_CLOSED,
    input  wire logic               LINE_POWER,
    input  wire logic               INLINE_FB,
    input  wire logic               INLINE_FB_ASSIGNED,
    input  wire logic [TMO_W-1:0]   INLINE_TIMEOUT,
    input  wire logic               BYPASS_FB,
    input  wire logic               BYPASS_FB_ASSIGNED,
    input  wire logic               BYPASS_RELAY_FAN,
    input  wire logic [TMO_W-1:0]   BYPASS_TIMEOUT,
    // Relay and gate drive
    output logic                    RUN_RELAY,
    output logic                    BYPASS_RELAY,
    output logic                    AT_SPEED_RELAY,
    output logic [5:0]              GATE_STRING,
    // Display
    output logic [3:0]              SHOW_CODE,
    output logic [2:0]              SHOW_GATE,
    // Event recorder and system
    output logic                    EVENT_VALID,
    output logic [7:0]              EVENT_CODE,
    output logic                    SYSTEM_RESET,
    output logic                    BUSY
);
    initial begin
        if (CLK_HZ < 1)
            $error("Clock frequency must be positive");
        if (TMO_W < 1 || TMO_W > 24 || TMO_UNIT < 1 || TMO_UNIT > 64'hffffff)
            $error("Unsupported timeout parameters");
        if (RELAY_CYC < 1 || GATE_CYC < 1 || ALL_CYC < 1)
            $error("Step counts must be positive");
        if (RELAY_CYC > 64'hffffffffffff || GATE_CYC > 64'hffffffffffff
            || ALL_CYC > 64'hffffffffffff)
            $error("Step counts exceed the step timer");
        if (`TOTAL_CHECK_S != `TOTAL_TEST_S)
            $error("Step times do not sum to the nominal test length");
    end

    typedef struct packed {
        selftest_pkg::state_t state;
        logic [47:0]          timer;
        logic [47:0]          fb_timer;
        logic [2:0]           gate_idx;
        logic                 run;
        logic                 bypass;
        logic [5:0]           gates;
        logic [3:0]           show;
        logic [2:0]           show_gate;
        logic                 ev_valid;
        logic [7:0]           ev_code;
        logic                 sys_reset;
    } seq_t;

    seq_t s_reg;
    seq_t s_next;

    localparam logic [17:0] ORDER = `GATE_SEQ_ORDER;

    function automatic logic [2:0] gate_num(input logic [2:0] idx);
        gate_num = ORDER[3*(5-idx) +: 3];
    endfunction

    logic        il_active;
    logic        bp_active;
    logic [47:0] il_limit;
    logic [47:0] bp_limit;
    logic        abort_now;
    logic        il_miss;
    logic        bp_miss;
    logic [7:0]  abort_code;
    logic [2:0]  gate_pick;
    logic [5:0]  gate_hot;

    always_comb begin
        il_active = INLINE_FB_ASSIGNED;
        bp_active = !(BYPASS_RELAY_FAN && !BYPASS_FB_ASSIGNED);
        il_limit  = 48'(INLINE_TIMEOUT) * 48'(TMO_UNIT);
        bp_limit  = 48'(BYPASS_TIMEOUT) * 48'(TMO_UNIT);
        abort_now = DISCONNECT_CLOSED || LINE_POWER || !SELFTEST_CMD;
        il_miss   = il_active && INLINE_FB != s_reg.run && s_reg.fb_timer >= il_limit;
        bp_miss   = bp_active && BYPASS_FB != s_reg.bypass && s_reg.fb_timer >= bp_limit;
        if (DISCONNECT_CLOSED)
            abort_code = `EVT_ABORT_DISC;
        else if (LINE_POWER)
            abort_code = `EVT_ABORT_POWER;
        else
            abort_code = `EVT_ABORT_CMD;
        if (s_reg.state == selftest_pkg::ST_GATE_SEQ && s_reg.gate_idx != 3'h5)
            gate_pick = gate_num(s_reg.gate_idx + 3'h1);
        else
            gate_pick = gate_num(3'h0);
    end

    for (genvar g = 0; g < 6; g++) begin : gate_dec
        assign gate_hot[g] = (gate_pick == 3'(g + 1));
    end

    always_comb begin
        s_next = s_reg;
        s_next.ev_valid  = 1'b0;
        s_next.sys_reset = 1'b0;
        s_next.timer     = s_reg.timer + 48'h1;
        s_next.fb_timer  = s_reg.fb_timer + 48'h1;
        case (s_reg.state)
            selftest_pkg::ST_IDLE: begin
                s_next.show = selftest_pkg::SHOW_HOME;
                s_next.gates = 6'h00;
                s_next.gate_idx = 3'h0;
                s_next.show_gate = 3'h0;
                s_next.run = 1'b0;
                s_next.bypass = 1'b0;
                if (SELFTEST_CMD && !LINE_POWER) begin
                    s_next.state = selftest_pkg::ST_LOG_ENTER;
                    s_next.ev_valid = 1'b1;
                    s_next.ev_code = `EVT_ENTER;
                end
            end
            selftest_pkg::ST_LOG_ENTER: begin
                s_next.state = selftest_pkg::ST_WAIT_OPEN;
            end
            selftest_pkg::ST_WAIT_OPEN: begin
                if (!SELFTEST_CMD || LINE_POWER) begin
                    s_next.state = selftest_pkg::ST_ABORT;
                    s_next.show = selftest_pkg::SHOW_CANCEL;
                    s_next.ev_valid = 1'b1;
                    s_next.ev_code = LINE_POWER ? `EVT_ABORT_POWER : `EVT_ABORT_CMD;
                end else if (DISCONNECT_CLOSED) begin
                    s_next.state = selftest_pkg::ST_WAIT_OPEN;
                    s_next.show = selftest_pkg::SHOW_OPEN_DISC;
                end else begin
                    s_next.timer = 48'h0;
                    s_next.fb_timer = 48'h0;
                    if (INLINE_TIMEOUT == '0) begin
                        s_next.state = selftest_pkg::ST_BP_CLOSE;
                        s_next.bypass = 1'b1;
                        s_next.show = selftest_pkg::SHOW_BP_CLOSED;
                    end else begin
                        s_next.state = selftest_pkg::ST_IL_CLOSE;
                        s_next.run = 1'b1;
                        s_next.show = selftest_pkg::SHOW_IL_CLOSED;
                    end
                end
            end
            selftest_pkg::ST_IL_CLOSE, selftest_pkg::ST_IL_OPEN: begin
                if (il_miss) begin
                    s_next.state = selftest_pkg::ST_FAULT;
                    s_next.run = 1'b0;
                    s_next.bypass = 1'b0;
                    s_next.show = selftest_pkg::SHOW_FAULT;
                    s_next.ev_valid = 1'b1;
                    s_next.ev_code = `FAULT_INLINE;
                end else if (ENTER_KEY || s_reg.timer >= RELAY_CYC - 1) begin
                    s_next.timer = 48'h0;
                    s_next.fb_timer = 48'h0;
                    if (s_reg.state == selftest_pkg::ST_IL_CLOSE) begin
                        s_next.state = selftest_pkg::ST_IL_OPEN;
                        s_next.run = 1'b0;
                        s_next.show = selftest_pkg::SHOW_IL_OPEN;
                    end else begin
                        s_next.state = selftest_pkg::ST_BP_CLOSE;
                        s_next.bypass = 1'b1;
                        s_next.show = selftest_pkg::SHOW_BP_CLOSED;
                    end
                end
            end
            selftest_pkg::ST_BP_CLOSE, selftest_pkg::ST_BP_OPEN: begin
                if (bp_miss) begin
                    s_next.state = selftest_pkg::ST_FAULT;
                    s_next.run = 1'b0;
                    s_next.bypass = 1'b0;
                    s_next.show = selftest_pkg::SHOW_FAULT;
                    s_next.ev_valid = 1'b1;
                    s_next.ev_code = `FAULT_BYPASS;
                end else if (ENTER_KEY || s_reg.timer >= RELAY_CYC - 1) begin
                    s_next.timer = 48'h0;
                    s_next.fb_timer = 48'h0;
                    if (s_reg.state == selftest_pkg::ST_BP_CLOSE) begin
                        s_next.state = selftest_pkg::ST_BP_OPEN;
                        s_next.bypass = 1'b0;
                        s_next.show = selftest_pkg::SHOW_BP_OPEN;
                    end else begin
                        s_next.state = selftest_pkg::ST_GATE_SEQ;
                        s_next.gate_idx = 3'h0;
                        s_next.gates = gate_hot;
                        s_next.show_gate = gate_pick;
                        s_next.show = selftest_pkg::SHOW_GATE_N;
                    end
                end
            end
            selftest_pkg::ST_GATE_SEQ: begin
                if (ENTER_KEY || s_reg.timer >= GATE_CYC - 1) begin
                    s_next.timer = 48'h0;
                    if (ENTER_KEY || s_reg.gate_idx == 3'h5) begin
                        s_next.state = selftest_pkg::ST_GATE_ALL;
                        s_next.gates = 6'h3f;
                        s_next.show = selftest_pkg::SHOW_ALL_GATES;
                    end else begin
                        s_next.gate_idx = s_reg.gate_idx + 3'h1;
                        s_next.gates = gate_hot;
                        s_next.show_gate = gate_pick;
                    end
                end
            end
            selftest_pkg::ST_GATE_ALL: begin
                if (ENTER_KEY || s_reg.timer >= ALL_CYC - 1) begin
                    s_next.state = selftest_pkg::ST_PASS;
                    s_next.gates = 6'h00;
                    s_next.show = selftest_pkg::SHOW_PASSED;
                    s_next.ev_valid = 1'b1;
                    s_next.ev_code = `EVT_PASS;
                end
            end
            selftest_pkg::ST_PASS: begin
                s_next.sys_reset = 1'b1;
                s_next.state = selftest_pkg::ST_IDLE;
            end
            selftest_pkg::ST_FAULT, selftest_pkg::ST_ABORT: begin
                s_next.run = 1'b0;
                s_next.bypass = 1'b0;
                s_next.gates = 6'h00;
                s_next.show = (s_reg.state == selftest_pkg::ST_FAULT)
                    ? selftest_pkg::SHOW_FAULT : selftest_pkg::SHOW_CANCEL;
                if (!SELFTEST_CMD)
                    s_next.state = selftest_pkg::ST_IDLE;
            end
            default: begin
                s_next.state = selftest_pkg::ST_IDLE;
            end
        endcase
        if (abort_now && s_reg.state inside {selftest_pkg::ST_IL_CLOSE,
            selftest_pkg::ST_IL_OPEN, selftest_pkg::ST_BP_CLOSE, selftest_pkg::ST_BP_OPEN,
            selftest_pkg::ST_GATE_SEQ, selftest_pkg::ST_GATE_ALL}) begin
            s_next.state = selftest_pkg::ST_ABORT;
            s_next.run = 1'b0;
            s_next.bypass = 1'b0;
            s_next.gates = 6'h00;
            s_next.show = selftest_pkg::SHOW_CANCEL;
            s_next.ev_valid = 1'b1;
            s_next.ev_code = abort_code;
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs
    always_comb begin
        RUN_RELAY      = s_reg.run;
        BYPASS_RELAY   = s_reg.bypass;
        AT_SPEED_RELAY = s_reg.bypass;
        GATE_STRING    = s_reg.gates;
        SHOW_CODE      = s_reg.show;
        SHOW_GATE      = s_reg.show_gate;
        EVENT_VALID    = s_reg.ev_valid;
        EVENT_CODE     = s_reg.ev_code;
        SYSTEM_RESET   = s_reg.sys_reset;
        BUSY           = (s_reg.state != selftest_pkg::ST_IDLE);
    end
endmodule : starter_selftest_sequencer

// ==== test/selftest_props.sv ====
// Port checker for the starter self-test sequencer
// Assumes a bind to every instance of starter_selftest_sequencer
`timescale 1ns/100ps
module selftest_props (
    // Clock, reset and commands
    input wire logic       CLOCK, ARST_N, SELFTEST_CMD, ENTER_KEY,
    // Plant state
    input wire logic       DISCONNECT_CLOSED, LINE_POWER,
    // Drive and display
    input wire logic       RUN_RELAY, BYPASS_RELAY, AT_SPEED_RELAY,
    input wire logic [5:0] GATE_STRING,
    input wire logic [3:0] SHOW_CODE,
    input wire logic [2:0] SHOW_GATE,
    // Events
    input wire logic       EVENT_VALID, SYSTEM_RESET, BUSY,
    input wire logic [7:0] EVENT_CODE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);

    enter_event_a: assert property (
        !BUSY && SELFTEST_CMD && !LINE_POWER |=> EVENT_VALID && EVENT_CODE == 8'hc1)
        else $error("entry event missing");
    hold_off_a: assert property (
        SHOW_CODE == 4'h1 |-> !RUN_RELAY && !BYPASS_RELAY && GATE_STRING == 6'h00)
        else $error("drive active while disconnect prompt shown");
    gate_single_a: assert property (
        SHOW_CODE == 4'h6 |-> GATE_STRING == (6'h01 << (SHOW_GATE - 3'h1)))
        else $error("fired string differs from shown number");
    bypass_pair_a: assert property (
        BYPASS_RELAY == AT_SPEED_RELAY)
        else $error("bypass and at-speed relays differ");
    all_gates_a: assert property (
        SHOW_CODE == 4'h7 |-> GATE_STRING == 6'h3f)
        else $error("not all gates on");
    pass_reset_a: assert property (
        EVENT_VALID && EVENT_CODE == 8'hc3 |=> SYSTEM_RESET)
        else $error("no system reset after pass");
    event_pulse_a: assert property (
        EVENT_VALID |=> !EVENT_VALID)
        else $error("event longer than one cycle");
    power_abort_a: assert property (
        BUSY && LINE_POWER && SELFTEST_CMD && !DISCONNECT_CLOSED
        && SHOW_CODE inside {[4'h1:4'h7]} |-> ##[1:3] EVENT_VALID && EVENT_CODE == 8'hc5)
        else $error("power abort not logged");
    fault_off_a: assert property (
        SHOW_CODE == 4'h9 |-> !RUN_RELAY && !AT_SPEED_RELAY && GATE_STRING == 6'h00)
        else $error("drive active after fault");

    cover property (EVENT_VALID && EVENT_CODE == 8'hc3);
    cover property (EVENT_VALID && EVENT_CODE == 8'h31);
    cover property (SHOW_CODE == 4'h6 && ENTER_KEY);
endmodule : selftest_props

bind starter_selftest_sequencer selftest_props selftest_props_inst (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .SELFTEST_CMD(SELFTEST_CMD), .ENTER_KEY(ENTER_KEY),
    .DISCONNECT_CLOSED(DISCONNECT_CLOSED), .LINE_POWER(LINE_POWER),
    .RUN_RELAY(RUN_RELAY), .BYPASS_RELAY(BYPASS_RELAY), .AT_SPEED_RELAY(AT_SPEED_RELAY),
    .GATE_STRING(GATE_STRING), .SHOW_CODE(SHOW_CODE), .SHOW_GATE(SHOW_GATE),
    .EVENT_VALID(EVENT_VALID), .SYSTEM_RESET(SYSTEM_RESET), .BUSY(BUSY),
    .EVENT_CODE(EVENT_CODE));

// ==== test/contact_model.sv ====
// Auxiliary contacts of the in-line and bypass contactors
// Assumes relay levels from the sequencer; stuck inputs come from the bench
`timescale 1ns/100ps
module contact_model (
    // Clock and relays
    input wire logic clock, run_relay, bypass_relay,
    // Faults commanded by the bench
    input wire logic stuck_inline, stuck_bypass,
    // Feedback
    output logic     inline_fb, bypass_fb
);
    logic [2:0] il_reg;
    logic [2:0] bp_reg;
    // Contacts follow the coil three cycles late, or never close when stuck
    always_ff @(posedge clock) begin
        il_reg <= {il_reg[1:0], run_relay & ~stuck_inline};
        bp_reg <= {bp_reg[1:0], bypass_relay & ~stuck_bypass};
    end
    assign inline_fb = il_reg[2];
    assign bypass_fb = bp_reg[2];
endmodule : contact_model

// ==== test/tb.sv ====
// Self-checking bench of the starter self-test sequencer
// Assumes shortened step counts and the contact model on the feedback inputs
`timescale 1ns/100ps
module tb;
    logic clock = 0, arst_n = 0, cmd = 0, enter = 0, disc = 0, power = 0;
    logic il_fb, il_asg = 1, bp_fb, bp_asg = 1, fan = 0, stuck_il = 0, stuck_bp = 0;
    logic [15:0] il_tmo = 16'h0005, bp_tmo = 16'h0005;
    logic run, byp, at_speed_relay, evt, sysrst, busy;
    logic [5:0] gates;
    logic [3:0] show;
    logic [2:0] gnum;
    logic [7:0] code;
    int n_fail = 0, n_checks = 0;

    always #2.5 clock = ~clock;

    starter_selftest_sequencer #(.RELAY_CYC(20), .GATE_CYC(20), .ALL_CYC(20), .TMO_UNIT(2))
    starter_selftest_sequencer_inst (
        .CLOCK(clock), .ARST_N(arst_n), .SELFTEST_CMD(cmd), .ENTER_KEY(enter),
        .DISCONNECT_CLOSED(disc), .LINE_POWER(power), .INLINE_FB(il_fb),
        .INLINE_FB_ASSIGNED(il_asg), .INLINE_TIMEOUT(il_tmo), .BYPASS_FB(bp_fb),
        .BYPASS_FB_ASSIGNED(bp_asg), .BYPASS_RELAY_FAN(fan), .BYPASS_TIMEOUT(bp_tmo),
        .RUN_RELAY(run), .BYPASS_RELAY(byp), .AT_SPEED_RELAY(at_speed_relay), .GATE_STRING(gates),
        .SHOW_CODE(show), .SHOW_GATE(gnum), .EVENT_VALID(evt), .EVENT_CODE(code),
        .SYSTEM_RESET(sysrst), .BUSY(busy));

    contact_model contact_model_inst (
        .clock(clock), .run_relay(run), .bypass_relay(byp), .stuck_inline(stuck_il),
        .stuck_bypass(stuck_bp), .inline_fb(il_fb), .bypass_fb(bp_fb));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic wait_show(input logic [3:0] s);
        for (int i = 0; i < 400 && show !== s; i++) @(negedge clock);
        check(show, s);
    endtask : wait_show

    task automatic wait_evt(input logic [7:0] c);
        for (int i = 0; i < 400 && evt !== 1'b1; i++) @(negedge clock);
        check(code, c);
        @(negedge clock);
    endtask : wait_evt

    task automatic press;
        enter = 1;
        @(negedge clock);
        enter = 0;
    endtask : press

    task automatic stop;
        cmd = 0;
        @(negedge clock);
        for (int i = 0; i < 50 && busy !== 1'b0; i++) @(negedge clock);
        check(busy, 1'b0);
    endtask : stop

    task automatic t_pass;
        int g[6] = '{6, 3, 5, 2, 4, 1};
        longint t0;
        disc = 1;
        cmd = 1;
        wait_evt(8'hc1);
        repeat (5) @(negedge clock);
        check(show, 4'h1);
        disc = 0;
        wait_show(4'h2);
        t0 = $time;
        check(run, 1'b1);
        wait_show(4'h3);
        check(run, 1'b0);
        wait_show(4'h4);
        check(at_speed_relay, 1'b1);
        check(byp, 1'b1);
        wait_show(4'h5);
        foreach (g[i]) begin
            for (int k = 0; k < 400 && gnum !== g[i][2:0]; k++) @(negedge clock);
            check(gnum, g[i][2:0]);
            check(gates, 8'h01 << (g[i] - 1));
        end
        wait_show(4'h7);
        check(gates, 8'h3f);
        check(8'(($time - t0) / 5), 8'hc8);
        press;
        check(evt, 1'b1);
        wait_evt(8'hc3);
        check(sysrst, 1'b1);
        stop;
    endtask : t_pass

    task automatic t_skip;
        il_tmo = 16'h0000;
        cmd = 1;
        wait_evt(8'hc1);
        repeat (4) @(negedge clock);
        check(show, 4'h4);
        press;
        check(show, 4'h5);
        wait_show(4'h6);
        press;
        check(show, 4'h7);
        @(negedge clock);
        press;
        wait_evt(8'hc3);
        stop;
        il_tmo = 16'h0005;
    endtask : t_skip

    task automatic t_faults;
        stuck_il = 1;
        cmd = 1;
        wait_evt(8'hc1);
        wait_evt(8'h31);
        check(show, 4'h9);
        stop;
        stuck_il = 0;
        stuck_bp = 1;
        cmd = 1;
        wait_evt(8'hc1);
        wait_evt(8'h30);
        stop;
        il_asg = 0;
        stuck_il = 1;
        bp_asg = 0;
        fan = 1;
        cmd = 1;
        wait_evt(8'hc1);
        wait_show(4'h4);
        wait_show(4'h6);
        stop;
        {il_asg, bp_asg, fan, stuck_il, stuck_bp} = 5'b11000;
    endtask : t_faults

    task automatic t_abort;
        logic [7:0] c[3] = '{8'hc4, 8'hc5, 8'hc6};
        for (int k = 0; k < 3; k++) begin
            cmd = 1;
            wait_evt(8'hc1);
            wait_show(4'h2);
            if (k == 0) disc = 1;
            else if (k == 1) power = 1;
            else cmd = 0;
            wait_evt(c[k]);
            disc = 0;
            power = 0;
            stop;
        end
    endtask : t_abort

    initial begin
        repeat (20) @(negedge clock);
        arst_n = 1;
        @(negedge clock);
        t_pass;
        t_skip;
        t_faults;
        t_abort;
        finish_test;
    end

    initial begin
        #(20000 * 5);
        n_fail++;
        finish_test;
    end
endmodule : tb
